// ---- src/rsd_pkg.sv ----
// Constants shared by the descriptor status write-back block
// How it works
// - After each descriptor, bytes actually moved go into status bits 22 to 0.
// - A clean completion reports exactly the length the control word asked for.
// - Width parameter sizes the byte field; at most 8,388,607 bytes expressible.
// - Micro build leaves the transferred-byte field of the status word unwritten.
// - Zero buffer length issues a zero-length mover command and sets internal fault.
// - Slave-error read response sets the slave fault flag, bit 29.
// - Decode-error read response sets the decode fault flag, bit 30.
// - Any of those faults clears run/stop, then sets stopped after full shutdown.
// - A finished descriptor gets its completion flag, bit 31, set to 1.
// - A fetched descriptor already marked complete is stale: chain fault and halt.
// - Requested length is control bits 22 to 0, limited by the same width.
package rsd_pkg;
  // ----------------------------------------
  // Status word layout
  // ----------------------------------------
  localparam int STAT_BYTES_MSB = 22;
  localparam int STAT_RSVD_LSB = 23;
  localparam int STAT_INT_BIT = 28;
  localparam int STAT_SLV_BIT = 29;
  localparam int STAT_DEC_BIT = 30;
  localparam int STAT_CMPLT_BIT = 31;
  localparam int LEN_W_MAX = 23;
  localparam int unsigned MAX_BYTES = 8388607;
  localparam logic [3:0] STRB_FULL = 4'hf;
  localparam logic [3:0] STRB_MICRO = 4'h8;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_LAST = 8'h08;
  localparam logic [7:0] OFS_DONE = 8'h0c;
  localparam int CTRL_RS_BIT = 0;
  localparam int ST_STOP_BIT = 0;
  localparam int ST_IDLE_BIT = 1;
  localparam int ST_INT_BIT = 4;
  localparam int ST_SLV_BIT = 5;
  localparam int ST_DEC_BIT = 6;
  localparam int ST_CHAIN_BIT = 7;
  localparam logic RST_RUN = 1'b0;
  localparam logic RST_STOPPED = 1'b1;
  // ----------------------------------------
  // Bus and read response codes
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ----------------------------------------
  // Engine states
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CMD = 5'h02,
    ST_RUN = 5'h04,
    ST_WB = 5'h08,
    ST_HALT = 5'h10
  } rsd_state_t;
endpackage

// ---- src/rsd_acc_if.sv ----
// Carrier between the engine and its status accumulator
`timescale 1ns/1ps
interface rsd_acc_if #(
  parameter int LEN_W = 23,
  parameter int BEAT_W = 8
);
  logic clr;
  logic add;
  logic [BEAT_W-1:0] add_bytes;
  logic [1:0] add_resp;
  logic zero_len;
  logic [LEN_W-1:0] count;
  logic flt_int;
  logic flt_slv;
  logic flt_dec;
  modport acc (input clr, add, add_bytes, add_resp, zero_len,
               output count, flt_int, flt_slv, flt_dec);
  modport ctl (output clr, add, add_bytes, add_resp, zero_len,
               input count, flt_int, flt_slv, flt_dec);
endinterface

// ---- src/rsd_acc.sv ----
// Byte counter and fault collector for one descriptor
`timescale 1ns/1ps
module rsd_acc #(
  parameter int LEN_W = 23,
  parameter int BEAT_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  rsd_acc_if.acc a
);
  logic [LEN_W-1:0] count_r;
  logic flt_int_r;
  logic flt_slv_r;
  logic flt_dec_r;
  wire [LEN_W-1:0] sum_w = count_r + LEN_W'(a.add_bytes);
  wire is_slv = a.add && (a.add_resp == rsd_pkg::RESP_SLVERR);
  wire is_dec = a.add && (a.add_resp == rsd_pkg::RESP_DECERR);

  always_ff @(posedge aclk) begin
    if (!aresetn || a.clr) begin
      count_r <= '0;
      flt_int_r <= 1'b0;
      flt_slv_r <= 1'b0;
      flt_dec_r <= 1'b0;
    end else begin
      if (a.add) begin
        count_r <= sum_w;
      end
      flt_int_r <= flt_int_r | a.zero_len;
      flt_slv_r <= flt_slv_r | is_slv;
      flt_dec_r <= flt_dec_r | is_dec;
    end
  end

  assign a.count = count_r;
  assign a.flt_int = flt_int_r;
  assign a.flt_slv = flt_slv_r;
  assign a.flt_dec = flt_dec_r;
endmodule

// ---- src/rsd_engine.sv ----
// Read-path descriptor status engine with its register slave
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module rsd_engine #(
  parameter int LEN_W = 23,
  parameter int BEAT_W = 8,
  parameter bit MICRO = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic desc_valid,
  output logic desc_ready,
  input wire logic [31:0] desc_ctrl,
  input wire logic [31:0] desc_stat,
  output logic mov_cmd_valid,
  input wire logic mov_cmd_ready,
  output logic [LEN_W-1:0] mov_cmd_len,
  input wire logic mov_beat_valid,
  output logic mov_beat_ready,
  input wire logic [BEAT_W-1:0] mov_beat_bytes,
  input wire logic [1:0] mov_beat_resp,
  input wire logic mov_beat_last,
  output logic wb_valid,
  input wire logic wb_ready,
  output logic [31:0] wb_data,
  output logic [3:0] wb_strb
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (LEN_W < 8 || LEN_W > rsd_pkg::LEN_W_MAX) begin : g_bad_len
    $error("LEN_W must lie in 8..23");
  end
  if (BEAT_W < 1 || BEAT_W > LEN_W) begin : g_bad_beat
    $error("BEAT_W must lie in 1..LEN_W");
  end

  // ----------------------------------------
  // Engine state and control registers
  // ----------------------------------------
  rsd_pkg::rsd_state_t state_r;
  rsd_pkg::rsd_state_t state_nxt;
  logic run_stop_r;
  logic stopped_r;
  logic sw_int_r;
  logic sw_slv_r;
  logic sw_dec_r;
  logic chain_r;
  logic [LEN_W-1:0] len_r;
  logic [31:0] last_r;
  logic [31:0] done_cnt_r;
  logic [31:0] wb_data_r;
  logic [3:0] wb_strb_r;

  rsd_acc_if #(.LEN_W(LEN_W), .BEAT_W(BEAT_W)) acc_bus ();

  rsd_acc #(.LEN_W(LEN_W), .BEAT_W(BEAT_W)) u_acc (
    .aclk(aclk),
    .aresetn(aresetn),
    .a(acc_bus)
  );

  // ----------------------------------------
  // Descriptor decode
  // ----------------------------------------
  wire [LEN_W-1:0] req_len = desc_ctrl[LEN_W-1:0];
  wire stale = desc_stat[rsd_pkg::STAT_CMPLT_BIT];
  wire zero_len = (req_len == '0);
  wire desc_take = desc_valid && desc_ready;
  wire cmd_take = mov_cmd_valid && mov_cmd_ready;
  wire beat_take = mov_beat_valid && mov_beat_ready;
  wire wb_take = wb_valid && wb_ready;
  wire any_fault = acc_bus.flt_int | acc_bus.flt_slv | acc_bus.flt_dec;
  wire beat_slv = beat_take && (mov_beat_resp == rsd_pkg::RESP_SLVERR);
  wire beat_dec = beat_take && (mov_beat_resp == rsd_pkg::RESP_DECERR);
  wire fault_now = beat_slv | beat_dec | (cmd_take && (len_r == '0));
  wire idle_now = (state_r == rsd_pkg::ST_IDLE);

  assign desc_ready = idle_now && run_stop_r;
  assign mov_cmd_valid = (state_r == rsd_pkg::ST_CMD);
  assign mov_cmd_len = len_r;
  assign mov_beat_ready = (state_r == rsd_pkg::ST_RUN);
  assign wb_valid = (state_r == rsd_pkg::ST_WB);
  assign wb_data = wb_data_r;
  assign wb_strb = wb_strb_r;

  assign acc_bus.clr = desc_take;
  assign acc_bus.add = beat_take;
  assign acc_bus.add_bytes = mov_beat_bytes;
  assign acc_bus.add_resp = mov_beat_resp;
  assign acc_bus.zero_len = cmd_take && (len_r == '0);

  // ----------------------------------------
  // Status word assembly
  // ----------------------------------------
  // Fold in the beat or command taken on the capture edge itself
  wire [LEN_W-1:0] beat_add = beat_take ? LEN_W'(mov_beat_bytes) : LEN_W'(0);
  wire [LEN_W-1:0] count_now = acc_bus.count + beat_add;
  logic [31:0] stat_word;
  always_comb begin
    stat_word = '0;
    stat_word[LEN_W-1:0] = count_now;
    stat_word[rsd_pkg::STAT_INT_BIT] = acc_bus.flt_int | acc_bus.zero_len;
    stat_word[rsd_pkg::STAT_SLV_BIT] = acc_bus.flt_slv | beat_slv;
    stat_word[rsd_pkg::STAT_DEC_BIT] = acc_bus.flt_dec | beat_dec;
    stat_word[rsd_pkg::STAT_CMPLT_BIT] = 1'b1;
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rsd_pkg::ST_IDLE: begin
        if (desc_take) begin
          state_nxt = stale ? rsd_pkg::ST_HALT : rsd_pkg::ST_CMD;
        end
      end
      rsd_pkg::ST_CMD: begin
        if (cmd_take) begin
          state_nxt = (len_r == '0) ? rsd_pkg::ST_WB : rsd_pkg::ST_RUN;
        end
      end
      rsd_pkg::ST_RUN: begin
        if (beat_take && mov_beat_last) begin
          state_nxt = rsd_pkg::ST_WB;
        end
      end
      rsd_pkg::ST_WB: begin
        if (wb_take) begin
          state_nxt = any_fault ? rsd_pkg::ST_HALT : rsd_pkg::ST_IDLE;
        end
      end
      rsd_pkg::ST_HALT: begin
        state_nxt = rsd_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = rsd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= rsd_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Latch requested length and present the write-back word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      len_r <= '0;
      wb_data_r <= '0;
      wb_strb_r <= '0;
    end else begin
      if (desc_take) begin
        len_r <= req_len;
      end
      if (state_nxt == rsd_pkg::ST_WB && state_r != rsd_pkg::ST_WB) begin
        wb_data_r <= stat_word;
        wb_strb_r <= MICRO ? rsd_pkg::STRB_MICRO : rsd_pkg::STRB_FULL;
      end
    end
  end

  // ----------------------------------------
  // Register bus slave
  // ----------------------------------------
  logic aw_full_r;
  logic w_full_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  assign s_axi_awready = !aw_full_r && !bvalid_r;
  assign s_axi_wready = !w_full_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_do = aw_full_r && w_full_r;
  wire wr_ctrl = wr_do && (aw_addr_r == rsd_pkg::OFS_CTRL);
  wire wr_hit = wr_ctrl || (aw_addr_r == rsd_pkg::OFS_STAT) ||
                (aw_addr_r == rsd_pkg::OFS_LAST) || (aw_addr_r == rsd_pkg::OFS_DONE);
  wire rs_wr = wr_ctrl && w_strb_r[0];
  wire rs_set = rs_wr && w_data_r[rsd_pkg::CTRL_RS_BIT] && !run_stop_r;
  wire rs_clr = rs_wr && !w_data_r[rsd_pkg::CTRL_RS_BIT];
  wire ar_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= rsd_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? rsd_pkg::RESP_OKAY : rsd_pkg::RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  logic [31:0] stat_reg;
  always_comb begin
    stat_reg = '0;
    stat_reg[rsd_pkg::ST_STOP_BIT] = stopped_r;
    stat_reg[rsd_pkg::ST_IDLE_BIT] = idle_now;
    stat_reg[rsd_pkg::ST_INT_BIT] = sw_int_r;
    stat_reg[rsd_pkg::ST_SLV_BIT] = sw_slv_r;
    stat_reg[rsd_pkg::ST_DEC_BIT] = sw_dec_r;
    stat_reg[rsd_pkg::ST_CHAIN_BIT] = chain_r;
  end

  wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
  wire rd_ctrl = (rd_addr == rsd_pkg::OFS_CTRL);
  wire rd_stat = (rd_addr == rsd_pkg::OFS_STAT);
  wire rd_last = (rd_addr == rsd_pkg::OFS_LAST);
  wire rd_done = (rd_addr == rsd_pkg::OFS_DONE);
  wire rd_hit = rd_ctrl | rd_stat | rd_last | rd_done;
  wire [31:0] rd_val = rd_ctrl ? {31'h0, run_stop_r} :
                       rd_stat ? stat_reg :
                       rd_last ? last_r :
                       rd_done ? done_cnt_r : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= rsd_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_hit ? rsd_pkg::RESP_OKAY : rsd_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Run, halt and software-visible faults
  // ----------------------------------------
  wire halt_done = (state_r == rsd_pkg::ST_HALT);
  wire stale_hit = desc_take && stale;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_stop_r <= rsd_pkg::RST_RUN;
      stopped_r <= rsd_pkg::RST_STOPPED;
    end else begin
      if (fault_now || stale_hit || rs_clr) begin
        run_stop_r <= 1'b0;
      end else if (rs_set) begin
        run_stop_r <= 1'b1;
      end
      if (halt_done || (rs_clr && idle_now)) begin
        stopped_r <= 1'b1;
      end else if (rs_set) begin
        stopped_r <= 1'b0;
      end
    end
  end

  // Faults set wins over the clear done by a restart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_int_r <= 1'b0;
      sw_slv_r <= 1'b0;
      sw_dec_r <= 1'b0;
      chain_r <= 1'b0;
    end else begin
      sw_int_r <= acc_bus.zero_len | (sw_int_r & !rs_set);
      sw_slv_r <= beat_slv | (sw_slv_r & !rs_set);
      sw_dec_r <= beat_dec | (sw_dec_r & !rs_set);
      chain_r <= stale_hit | (chain_r & !rs_set);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_r <= '0;
      done_cnt_r <= '0;
    end else if (wb_take) begin
      last_r <= wb_data_r;
      done_cnt_r <= done_cnt_r + 32'h1;
    end
  end
endmodule

// ---- dv/rsd_engine_properties.sv ----
// Port-level checks for the descriptor status engine
`timescale 1ns/1ps
module rsd_engine_checker #(
  parameter int LEN_W = 23,
  parameter int BEAT_W = 8,
  parameter bit MICRO = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic desc_valid,
  input wire logic desc_ready,
  input wire logic [31:0] desc_stat,
  input wire logic [31:0] desc_ctrl,
  input wire logic mov_cmd_valid,
  input wire logic mov_cmd_ready,
  input wire logic [LEN_W-1:0] mov_cmd_len,
  input wire logic mov_beat_valid,
  input wire logic mov_beat_ready,
  input wire logic [BEAT_W-1:0] mov_beat_bytes,
  input wire logic [1:0] mov_beat_resp,
  input wire logic mov_beat_last,
  input wire logic wb_valid,
  input wire logic wb_ready,
  input wire logic [31:0] wb_data,
  input wire logic [3:0] wb_strb
);
  // ----------------------------------------
  // Byte sum and fault memory per descriptor
  // ----------------------------------------
  logic [LEN_W-1:0] sum_r;
  logic err_r;
  wire take_desc = desc_valid && desc_ready;
  wire take_beat = mov_beat_valid && mov_beat_ready;
  wire [LEN_W-1:0] len_req = desc_ctrl[LEN_W-1:0];
  wire [LEN_W-1:0] sum_nxt = sum_r + LEN_W'(mov_beat_bytes);
  wire beat_err = mov_beat_resp != rsd_pkg::RESP_OKAY;
  wire [3:0] strb_exp = MICRO ? rsd_pkg::STRB_MICRO : rsd_pkg::STRB_FULL;
  always_ff @(posedge aclk) begin
    if (!aresetn || take_desc) begin
      sum_r <= '0;
      err_r <= 1'b0;
    end else if (take_beat) begin
      sum_r <= sum_nxt;
      err_r <= err_r || beat_err;
    end
  end
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence last_beat;
    take_beat && mov_beat_last;
  endsequence
  sequence wb_taken;
    wb_valid && wb_ready;
  endsequence
  chk_wb_cmplt: assert property (wb_valid |-> wb_data[31])
    else $error("write-back without completion flag");
  chk_wb_lanes: assert property (wb_valid |-> wb_strb == strb_exp)
    else $error("write-back lanes wrong");
  chk_byte_count: assert property (last_beat |=> wb_valid &&
    (MICRO || wb_data[LEN_W-1:0] == $past(sum_nxt)))
    else $error("transferred byte count wrong");
  chk_zero_int: assert property (mov_cmd_valid && mov_cmd_ready && mov_cmd_len == '0
    |-> ##[1:8] wb_valid && wb_data[rsd_pkg::STAT_INT_BIT])
    else $error("zero length without internal fault");
  chk_slv_flag: assert property (last_beat ##0 mov_beat_resp == rsd_pkg::RESP_SLVERR
    |=> wb_data[rsd_pkg::STAT_SLV_BIT])
    else $error("slave fault flag missing");
  chk_dec_flag: assert property (last_beat ##0 mov_beat_resp == rsd_pkg::RESP_DECERR
    |=> wb_data[rsd_pkg::STAT_DEC_BIT])
    else $error("decode fault flag missing");
  chk_clean_flags: assert property (last_beat ##0 (!err_r && !beat_err)
    |=> wb_data[30:28] == 3'h0)
    else $error("fault flag on clean descriptor");
  chk_fault_stop: assert property (wb_taken ##0 wb_data[30:28] != 3'h0
    |=> !desc_ready [*4])
    else $error("engine accepts work after fault");
  chk_stale_drop: assert property (take_desc && desc_stat[31]
    |=> (!mov_cmd_valid && !wb_valid && !desc_ready) [*4])
    else $error("stale descriptor processed");
  chk_cmd_len: assert property (take_desc && !desc_stat[31]
    |=> mov_cmd_valid && mov_cmd_len == $past(len_req))
    else $error("command length differs from request");
endmodule

bind rsd_engine rsd_engine_checker #(.LEN_W(LEN_W), .BEAT_W(BEAT_W), .MICRO(MICRO))
  u_rsd_engine_checker (.*);

// ---- dv/rsd_mem_model.sv ----
// Behavioural descriptor memory and read mover facing the status engine
`timescale 1ns/1ps
module rsd_mem_model #(
  parameter int LEN_W = 23,
  parameter int BEAT_W = 8
) (
  input wire logic aclk,
  output logic desc_valid,
  input wire logic desc_ready,
  output logic [31:0] desc_ctrl,
  output logic [31:0] desc_stat,
  input wire logic mov_cmd_valid,
  output logic mov_cmd_ready,
  output logic mov_beat_valid,
  input wire logic mov_beat_ready,
  output logic [BEAT_W-1:0] mov_beat_bytes,
  output logic [1:0] mov_beat_resp,
  output logic mov_beat_last,
  input wire logic wb_valid,
  output logic wb_ready,
  input wire logic [31:0] wb_data,
  input wire logic [3:0] wb_strb
);
  localparam logic [BEAT_W-1:0] MAX_BEAT = '1;
  wire [3:0] hs = {wb_valid && wb_ready, mov_beat_valid && mov_beat_ready,
    mov_cmd_valid && mov_cmd_ready, desc_valid && desc_ready};
  logic [31:0] cap_d;
  logic [3:0] cap_s;
  initial begin
    {desc_valid, desc_ctrl, desc_stat, mov_cmd_ready, wb_ready} = '0;
    {mov_beat_valid, mov_beat_bytes, mov_beat_resp, mov_beat_last} = '0;
  end
  // ----------------------------------------
  // Handshakes, sampled before the edge
  // ----------------------------------------
  task automatic wait_hs(input int k, inout logic ok);
    logic got;
    int n;
    n = 0;
    got = 1'b0;
    while (!got && ok) begin
      @(negedge aclk);
      got = hs[k];
      cap_d = wb_data;
      cap_s = wb_strb;
      @(posedge aclk);
      n++;
      ok = got || n < 2000;
    end
  endtask
  task automatic run_desc(input logic [LEN_W-1:0] len, input logic [31:0] st,
      input logic [1:0] rsp, input bit slow, output logic [31:0] wbd,
      output logic [3:0] wbs, output logic ok);
    logic [LEN_W-1:0] left;
    logic [BEAT_W-1:0] b;
    ok = 1'b1;
    wbd = '0;
    wbs = '0;
    @(posedge aclk);
    desc_valid <= 1'b1;
    desc_ctrl <= 32'(len);
    desc_stat <= st;
    wait_hs(0, ok);
    desc_valid <= 1'b0;
    desc_ctrl <= ~desc_ctrl;
    desc_stat <= ~desc_stat;
    if (st[31]) return;
    if (slow) repeat (3) @(posedge aclk);
    mov_cmd_ready <= 1'b1;
    wait_hs(1, ok);
    mov_cmd_ready <= 1'b0;
    left = len;
    while (left != '0 && ok) begin
      b = (left > LEN_W'(MAX_BEAT)) ? MAX_BEAT : BEAT_W'(left);
      left = left - LEN_W'(b);
      mov_beat_valid <= 1'b1;
      mov_beat_bytes <= b;
      mov_beat_last <= left == '0;
      mov_beat_resp <= (left == '0) ? rsp : rsd_pkg::RESP_OKAY;
      wait_hs(2, ok);
      if (slow) begin
        mov_beat_valid <= 1'b0;
        mov_beat_bytes <= ~b;
        @(posedge aclk);
      end
    end
    mov_beat_valid <= 1'b0;
    if (slow) repeat (2) @(posedge aclk);
    wb_ready <= 1'b1;
    wait_hs(3, ok);
    wb_ready <= 1'b0;
    wbd = cap_d;
    wbs = cap_s;
  endtask
endmodule

// ---- dv/read_path_descriptor_status_bench.sv ----
// Bench: register bus task and a table of descriptors with expected status
`timescale 1ns/1ps
module read_path_descriptor_status_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, desc_ctrl, desc_stat, wb_data;
  logic [3:0] s_axi_wstrb, wb_strb;
  logic [1:0] s_axi_bresp, s_axi_rresp, mov_beat_resp;
  logic desc_valid, desc_ready, mov_cmd_valid, mov_cmd_ready, mov_beat_valid;
  logic mov_beat_ready, mov_beat_last, wb_valid, wb_ready;
  logic [22:0] mov_cmd_len;
  logic [7:0] mov_beat_bytes;
  int miscompares = 0;
  int checks_done = 0;
  logic [22:0] t_len [7] = '{23'h4, 23'h258, 23'h7fffff, 23'h8, 23'h8, 23'h0, 23'h4};
  logic [1:0] t_rsp [7] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h3, 2'h0, 2'h0};
  rsd_engine u_rsd_engine (.*);
  rsd_mem_model u_rsd_mem_model (.*);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // One register access, write or read
  // ----------------------------------------
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic [1:0] r);
    logic aw, w, ar, done;
    int n;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    if (wr) begin
      {s_axi_awaddr, s_axi_wdata} <= {a, wd};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    end else begin
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
    end
    while (!done) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      ar = s_axi_arvalid && s_axi_arready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      r = wr ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
      n++;
      if (n > 100) begin
        miscompares++;
        wrap_up();
      end
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
  endtask
  initial begin
    logic [31:0] d, e, m;
    logic [3:0] s;
    logic [1:0] r;
    logic ok;
    int fb;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi(0, rsd_pkg::OFS_STAT, 0, d, r);
    check("stopped at reset", d & 32'h1, 32'h1);
    axi(0, 8'h10, 0, d, r);
    check("unmapped response", {30'h0, r}, {30'h0, rsd_pkg::RESP_SLVERR});
    check("unmapped data", d, 32'h0);
    for (int i = 0; i < 7; i++) begin
      axi(1, rsd_pkg::OFS_CTRL, 32'h1, d, r);
      check("write response", {30'h0, r}, {30'h0, rsd_pkg::RESP_OKAY});
      u_rsd_mem_model.run_desc(t_len[i], {i == 6, 31'h0}, t_rsp[i], i == 1, d, s, ok);
      check("partner handshakes", {31'h0, ok}, 32'h1);
      e = {1'b1, t_rsp[i] == 2'h3, t_rsp[i] == 2'h2, t_len[i] == 0, 5'h0, t_len[i]};
      if (i < 6) begin
        check("status word", d, e);
        check("write lanes", {28'h0, s}, {28'h0, rsd_pkg::STRB_FULL});
      end
      fb = (i == 6) ? rsd_pkg::ST_CHAIN_BIT : e[30] ? rsd_pkg::ST_DEC_BIT :
        e[29] ? rsd_pkg::ST_SLV_BIT : e[28] ? rsd_pkg::ST_INT_BIT : -1;
      m = (fb < 0) ? 32'h1 : (32'h1 | (32'h1 << fb));
      axi(0, rsd_pkg::OFS_CTRL, 0, d, r);
      check("run stop", d & 32'h1, {31'h0, fb < 0});
      axi(0, rsd_pkg::OFS_STAT, 0, d, r);
      check("stopped and fault", d & m, (fb < 0) ? 32'h0 : m);
      $display("test %0d done", i);
    end
    axi(0, rsd_pkg::OFS_DONE, 0, d, r);
    check("write-back count", d, 32'h6);
    axi(0, rsd_pkg::OFS_LAST, 0, d, r);
    check("last status", d, 32'h90000000);
    wrap_up();
  end
endmodule
